/* File: rtl/bsr_pkg.sv */
package bsr_pkg;

  // Register addresses of the second bank (8-bit data-memory addresses)
  localparam logic [7:0] ADDR_INDIRECT_PORT   = 8'h80;
  localparam logic [7:0] ADDR_PRESCALER_CFG   = 8'h81;
  localparam logic [7:0] ADDR_PC_LOW          = 8'h82;
  localparam logic [7:0] ADDR_CPU_FLAGS       = 8'h83;
  localparam logic [7:0] ADDR_INDIRECT_PTR    = 8'h84;
  localparam logic [7:0] ADDR_PORT_A_DIR      = 8'h85;
  localparam logic [7:0] ADDR_PORT_B_DIR      = 8'h86;
  localparam logic [7:0] ADDR_PORT_C_DIR      = 8'h87;
  localparam logic [7:0] ADDR_PORT_D_DIR      = 8'h88;
  localparam logic [7:0] ADDR_PORT_E_DIR      = 8'h89;
  localparam logic [7:0] ADDR_COUNTER_LATCH   = 8'h8A;
  localparam logic [7:0] ADDR_IRQ_CONTROL     = 8'h8B;
  localparam logic [7:0] ADDR_PERIPH_IRQ_EN1  = 8'h8C;
  localparam logic [7:0] ADDR_PERIPH_IRQ_EN2  = 8'h8D;
  localparam logic [7:0] ADDR_POWER_CONTROL   = 8'h8E;
  localparam logic [7:0] ADDR_PERIOD_LIMIT    = 8'h92;
  localparam logic [7:0] ADDR_SERIAL_ADDR     = 8'h93;
  localparam logic [7:0] ADDR_SERIAL_STATE    = 8'h94;
  localparam logic [7:0] ADDR_TRANSMIT_CTRL   = 8'h98;
  localparam logic [7:0] ADDR_BAUD_DIVISOR    = 8'h99;
  localparam logic [7:0] ADDR_ANALOG_CFG      = 8'h9F;

  // Window of the bank and its mirrored bank-0 locations (low seven bits)
  localparam logic [6:0] BANK_TOP_OFFSET      = 7'h1F;
  localparam logic [6:0] MIRROR_PC_LOW        = 7'h02;
  localparam logic [6:0] MIRROR_CPU_FLAGS     = 7'h03;
  localparam logic [6:0] MIRROR_INDIRECT_PTR  = 7'h04;
  localparam logic [6:0] MIRROR_COUNTER_LATCH = 7'h0A;
  localparam logic [6:0] MIRROR_IRQ_CONTROL   = 7'h0B;
  localparam logic [6:0] INDIRECT_PORT_OFFSET = 7'h00;

  // Power-on / brown-out values (unknown bits taken as zero)
  localparam logic [7:0] RST_PRESCALER_CFG    = 8'hFF;
  localparam logic [7:0] RST_PC_LOW           = 8'h00;
  localparam logic [4:0] RST_PC_HIGH          = 5'h00;
  localparam logic [7:0] RST_CPU_FLAGS        = 8'h18;
  localparam logic [7:0] RST_INDIRECT_PTR     = 8'h00;
  localparam logic [5:0] RST_PORT_A_DIR       = 6'h3F;
  localparam logic [7:0] RST_PORT_B_DIR       = 8'hFF;
  localparam logic [7:0] RST_PORT_C_DIR       = 8'hFF;
  localparam logic [7:0] RST_PORT_D_DIR       = 8'hFF;
  localparam logic [2:0] RST_PORT_E_DIR       = 3'h7;
  localparam logic [4:0] RST_COUNTER_LATCH    = 5'h00;
  localparam logic [7:0] RST_IRQ_CONTROL      = 8'h00;
  localparam logic [7:0] RST_PERIPH_IRQ_EN1   = 8'h00;
  localparam logic [0:0] RST_PERIPH_IRQ_EN2   = 1'h0;
  localparam logic [1:0] RST_POWER_CONTROL    = 2'h0;
  localparam logic [7:0] RST_PERIOD_LIMIT     = 8'hFF;
  localparam logic [7:0] RST_SERIAL_ADDR      = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_CTRL    = 8'h02;
  localparam logic [7:0] RST_BAUD_DIVISOR     = 8'h00;
  localparam logic [2:0] RST_ANALOG_CFG       = 3'h0;

  // Field positions
  localparam int FLAG_INDIRECT_BANK  = 7;
  localparam int FLAG_UPPER_BANK     = 6;
  localparam int FLAG_LOWER_BANK     = 5;
  localparam int FLAG_TIMEOUT        = 4;
  localparam int FLAG_POWER_DOWN     = 3;
  localparam int IRQCTL_PIN_CHANGE_F = 0;
  localparam int FIFTH_IO_PORT_OVERFLOW      = 5;
  localparam int FIFTH_IO_PORT_SLAVE_MODE    = 4;
  localparam int POWER_CONTROL_POWER_ON       = 1;
  localparam int POWER_CONTROL_BROWNOUT       = 0;
  localparam int TXCTL_SHIFT_EMPTY   = 1;

  // Writable masks of mixed registers
  localparam logic [7:0] CPU_FLAGS_SW_MASK    = 8'hE7;
  localparam logic [7:0] TRANSMIT_CTRL_MASK   = 8'hF5;

endpackage

/* File: rtl/bsr_dec_if.sv */
`timescale 1ns/10ps
interface bsr_dec_if;
  logic [6:0] dirAddr;
  logic       upperBank;
  logic       lowerBank;
  logic       indirectBank;
  logic [7:0] pointer;
  logic [7:0] effAddr;
  logic       hit;
  logic       viaPointer;

  modport core (
    output dirAddr,
    output upperBank,
    output lowerBank,
    output indirectBank,
    output pointer,
    input  effAddr,
    input  hit,
    input  viaPointer
  );

  modport dec (
    input  dirAddr,
    input  upperBank,
    input  lowerBank,
    input  indirectBank,
    input  pointer,
    output effAddr,
    output hit,
    output viaPointer
  );
endinterface

/* File: rtl/bsr_addr_decode.sv */
`timescale 1ns/10ps
module bsr_addr_decode (
  bsr_dec_if.dec bus
);

  logic [8:0] fullAddr;
  logic       mirrored;

  // Direct access uses the bank bits; the indirect port uses the pointer
  always_comb begin
    bus.viaPointer = (bus.dirAddr == bsr_pkg::INDIRECT_PORT_OFFSET);
    if (bus.viaPointer) begin
      fullAddr = {bus.indirectBank, bus.pointer};
    end else begin
      fullAddr = {bus.upperBank, bus.lowerBank, bus.dirAddr};
    end
  end

  // Shared core registers answer in both banks
  always_comb begin
    case (fullAddr[6:0])
      bsr_pkg::INDIRECT_PORT_OFFSET,
      bsr_pkg::MIRROR_PC_LOW,
      bsr_pkg::MIRROR_CPU_FLAGS,
      bsr_pkg::MIRROR_INDIRECT_PTR,
      bsr_pkg::MIRROR_COUNTER_LATCH,
      bsr_pkg::MIRROR_IRQ_CONTROL: mirrored = 1'b1;
      default:                     mirrored = 1'b0;
    endcase
  end

  // With the upper bank bit clear: all of bank 1 when the lower bank bit is set, else only the mirrors are ours
  always_comb begin
    bus.effAddr = {1'b1, fullAddr[6:0]};
    bus.hit     = !fullAddr[8] && (fullAddr[6:0] <= bsr_pkg::BANK_TOP_OFFSET)
                  && (fullAddr[7] || mirrored);
  end

endmodule

/* File: rtl/bsr_bank1_regs.sv */
`timescale 1ns/10ps
// Function
// - No data address exposes the upper program counter bits directly.
// - A latch holds counter bits 12:8 and loads them when the counter loads.
// - Power-up values on power-on/brown-out; other values on pin or watchdog reset.
// - Unchanged bits keep their value; conditional bits follow the reset cause.
// - Unimplemented locations and bits read zero; writes to them do nothing.
// - Shared core registers are one physical register in both banks.
// - Without fourth and fifth ports their registers are absent and read zero.
// - Without brown-out detection the brown-out flag reads zero.
module bsr_bank1_regs #(
  parameter bit HAS_PORT_D_E   = 1'b1,
  parameter bit HAS_BROWNOUT   = 1'b1
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       otherReset,
  input  wire logic       resetByWatchdog,
  input  wire logic       resetInSleep,
  input  wire logic [6:0] dirAddr,
  input  wire logic       rdStb,
  input  wire logic       wrStb,
  input  wire logic [7:0] wrData,
  input  wire logic       aluFlagWe,
  input  wire logic [2:0] aluFlags,
  input  wire logic       pcStep,
  input  wire logic       pcBranch,
  input  wire logic [7:0] pcBranchLow,
  input  wire logic       sleepEnter,
  input  wire logic       watchdogClear,
  input  wire logic       pinChangeFlag,
  input  wire logic [1:0] slaveBufStatus,
  input  wire logic       slaveOverflowSet,
  input  wire logic [5:0] serialStatus,
  input  wire logic       txShiftEmpty,
  output logic      [7:0] rdData,
  output logic            rdHit,
  output logic      [4:0] pcHigh,
  output logic      [7:0] pcLow,
  output logic      [7:0] cpuFlags,
  output logic      [7:0] indirectPtr,
  output logic      [7:0] prescalerCfg,
  output logic      [5:0] portADir,
  output logic      [7:0] portBDir,
  output logic      [7:0] portCDir,
  output logic      [7:0] portDDir,
  output logic      [2:0] portEDir,
  output logic            slaveMode,
  output logic      [7:0] irqControl,
  output logic      [7:0] periphIrqEn1,
  output logic            periphIrqEn2,
  output logic      [7:0] periodLimit,
  output logic      [7:0] serialAddr,
  output logic      [7:0] transmitCtrl,
  output logic      [7:0] baudDivisor,
  output logic      [2:0] analogCfg
);

  typedef struct packed {
    logic [7:0] prescaler;
    logic [7:0] program_counter_low;
    logic [4:0] pch;
    logic [7:0] flags;
    logic [7:0] ptr;
    logic [5:0] dirA;
    logic [7:0] dirB;
    logic [7:0] dirC;
    logic [7:0] dirD;
    logic       slaveOvf;
    logic       slaveMode;
    logic [2:0] dirE;
    logic [4:0] latch;
    logic [7:0] irqCtl;
    logic [7:0] irqEn1;
    logic       irqEn2;
    logic [1:0] pwr;
    logic [7:0] period;
    logic [7:0] serAddr;
    logic [7:0] txCtl;
    logic [7:0] baud;
    logic [2:0] analog;
    logic [7:0] rdata;
    logic       hit;
  } bsr_state_t;

  localparam bsr_state_t RESET_STATE = '{
    prescaler: bsr_pkg::RST_PRESCALER_CFG,
    program_counter_low:       bsr_pkg::RST_PC_LOW,
    pch:       bsr_pkg::RST_PC_HIGH,
    flags:     bsr_pkg::RST_CPU_FLAGS,
    ptr:       bsr_pkg::RST_INDIRECT_PTR,
    dirA:      bsr_pkg::RST_PORT_A_DIR,
    dirB:      bsr_pkg::RST_PORT_B_DIR,
    dirC:      bsr_pkg::RST_PORT_C_DIR,
    dirD:      bsr_pkg::RST_PORT_D_DIR,
    slaveOvf:  1'b0,
    slaveMode: 1'b0,
    dirE:      bsr_pkg::RST_PORT_E_DIR,
    latch:     bsr_pkg::RST_COUNTER_LATCH,
    irqCtl:    bsr_pkg::RST_IRQ_CONTROL,
    irqEn1:    bsr_pkg::RST_PERIPH_IRQ_EN1,
    irqEn2:    bsr_pkg::RST_PERIPH_IRQ_EN2,
    pwr:       bsr_pkg::RST_POWER_CONTROL,
    period:    bsr_pkg::RST_PERIOD_LIMIT,
    serAddr:   bsr_pkg::RST_SERIAL_ADDR,
    txCtl:     bsr_pkg::RST_TRANSMIT_CTRL,
    baud:      bsr_pkg::RST_BAUD_DIVISOR,
    analog:    bsr_pkg::RST_ANALOG_CFG,
    rdata:     8'h00,
    hit:       1'b0
  };

  bsr_state_t state_q;
  bsr_state_t state_d;
  bsr_dec_if  decBus ();
  logic [7:0] readValue;
  logic [12:0] pcNext;

  // Address decode sees the live bank bits and pointer
  assign decBus.dirAddr      = dirAddr;
  assign decBus.upperBank    = state_q.flags[bsr_pkg::FLAG_UPPER_BANK];
  assign decBus.lowerBank    = state_q.flags[bsr_pkg::FLAG_LOWER_BANK];
  assign decBus.indirectBank = state_q.flags[bsr_pkg::FLAG_INDIRECT_BANK];
  assign decBus.pointer      = state_q.ptr;

  bsr_addr_decode uDecode (
    .bus (decBus)
  );

  assign pcNext = {state_q.pch, state_q.program_counter_low} + 13'h0001;

  // Read multiplexer; absent locations and bits fall through to zero
  always_comb begin
    readValue = 8'h00;
    case (decBus.effAddr)
      bsr_pkg::ADDR_PRESCALER_CFG:  readValue = state_q.prescaler;
      bsr_pkg::ADDR_PC_LOW:         readValue = state_q.program_counter_low;
      bsr_pkg::ADDR_CPU_FLAGS:      readValue = state_q.flags;
      bsr_pkg::ADDR_INDIRECT_PTR:   readValue = state_q.ptr;
      bsr_pkg::ADDR_PORT_A_DIR:     readValue = {2'h0, state_q.dirA};
      bsr_pkg::ADDR_PORT_B_DIR:     readValue = state_q.dirB;
      bsr_pkg::ADDR_PORT_C_DIR:     readValue = state_q.dirC;
      bsr_pkg::ADDR_PORT_D_DIR: begin
        if (HAS_PORT_D_E) begin
          readValue = state_q.dirD;
        end
      end
      bsr_pkg::ADDR_PORT_E_DIR: begin
        if (HAS_PORT_D_E) begin
          readValue = {slaveBufStatus, state_q.slaveOvf, state_q.slaveMode,
                       1'b0, state_q.dirE};
        end
      end
      bsr_pkg::ADDR_COUNTER_LATCH:  readValue = {3'h0, state_q.latch};
      bsr_pkg::ADDR_IRQ_CONTROL:    readValue = state_q.irqCtl;
      bsr_pkg::ADDR_PERIPH_IRQ_EN1: readValue = state_q.irqEn1;
      bsr_pkg::ADDR_PERIPH_IRQ_EN2: readValue = {7'h00, state_q.irqEn2};
      bsr_pkg::ADDR_POWER_CONTROL: begin
        readValue = {6'h00, state_q.pwr[bsr_pkg::POWER_CONTROL_POWER_ON],
                     state_q.pwr[bsr_pkg::POWER_CONTROL_BROWNOUT] & HAS_BROWNOUT};
      end
      bsr_pkg::ADDR_PERIOD_LIMIT:   readValue = state_q.period;
      bsr_pkg::ADDR_SERIAL_ADDR:    readValue = state_q.serAddr;
      bsr_pkg::ADDR_SERIAL_STATE:   readValue = {2'h0, serialStatus};
      bsr_pkg::ADDR_TRANSMIT_CTRL: begin
        readValue = state_q.txCtl & bsr_pkg::TRANSMIT_CTRL_MASK;
        readValue[bsr_pkg::TXCTL_SHIFT_EMPTY] = txShiftEmpty;
      end
      bsr_pkg::ADDR_BAUD_DIVISOR:   readValue = state_q.baud;
      bsr_pkg::ADDR_ANALOG_CFG:     readValue = {5'h00, state_q.analog};
      default:                      readValue = 8'h00;
    endcase
    // The indirect port pointing at itself reads zero, not a loop
    if (decBus.viaPointer && decBus.effAddr == bsr_pkg::ADDR_INDIRECT_PORT) begin
      readValue = 8'h00;
    end
  end

  // Next state: other resets first, then hardware events, then core writes, then the slave overflow set
  always_comb begin
    state_d     = state_q;
    state_d.hit = 1'b0;
    if (otherReset) begin
      // Fields take reset values; the cause flags follow the reset cause; the pointer, low flags, pin-change flag and power control are kept
      state_d       = RESET_STATE;
      state_d.ptr   = state_q.ptr;
      state_d.flags = {3'b000, !resetByWatchdog, !resetInSleep,
                       state_q.flags[2:0]};
      state_d.irqCtl[bsr_pkg::IRQCTL_PIN_CHANGE_F] =
        state_q.irqCtl[bsr_pkg::IRQCTL_PIN_CHANGE_F];
      state_d.pwr   = state_q.pwr;
    end else begin
      // Program counter stepping, with the latch feeding the upper bits
      if (pcBranch) begin
        state_d.program_counter_low = pcBranchLow;
        state_d.pch = state_q.latch;
      end else if (pcStep) begin
        state_d.program_counter_low = pcNext[7:0];
        state_d.pch = pcNext[12:8];
      end
      if (aluFlagWe) begin
        state_d.flags[2:0] = aluFlags;
      end
      if (sleepEnter) begin
        state_d.flags[bsr_pkg::FLAG_TIMEOUT]    = 1'b1;
        state_d.flags[bsr_pkg::FLAG_POWER_DOWN] = 1'b0;
      end else if (watchdogClear) begin
        state_d.flags[bsr_pkg::FLAG_TIMEOUT]    = 1'b1;
        state_d.flags[bsr_pkg::FLAG_POWER_DOWN] = 1'b1;
      end
      state_d.irqCtl[bsr_pkg::IRQCTL_PIN_CHANGE_F] =
        state_q.irqCtl[bsr_pkg::IRQCTL_PIN_CHANGE_F] | pinChangeFlag;
      // Registered at the clock edge ending the cycle, so visible next cycle
      if (wrStb && decBus.hit) begin
        case (decBus.effAddr)
          bsr_pkg::ADDR_PRESCALER_CFG:  state_d.prescaler = wrData;
          bsr_pkg::ADDR_PC_LOW: begin
            state_d.program_counter_low = wrData;
            state_d.pch = state_q.latch;
          end
          bsr_pkg::ADDR_CPU_FLAGS: begin
            // Timeout and power-down bits are not software writable
            state_d.flags = (wrData & bsr_pkg::CPU_FLAGS_SW_MASK)
                          | (state_d.flags & ~bsr_pkg::CPU_FLAGS_SW_MASK);
          end
          bsr_pkg::ADDR_INDIRECT_PTR:   state_d.ptr  = wrData;
          bsr_pkg::ADDR_PORT_A_DIR:     state_d.dirA = wrData[5:0];
          bsr_pkg::ADDR_PORT_B_DIR:     state_d.dirB = wrData;
          bsr_pkg::ADDR_PORT_C_DIR:     state_d.dirC = wrData;
          bsr_pkg::ADDR_PORT_D_DIR: begin
            if (HAS_PORT_D_E) begin
              state_d.dirD = wrData;
            end
          end
          bsr_pkg::ADDR_PORT_E_DIR: begin
            if (HAS_PORT_D_E) begin
              state_d.slaveOvf  = wrData[bsr_pkg::FIFTH_IO_PORT_OVERFLOW] & state_q.slaveOvf;
              state_d.slaveMode = wrData[bsr_pkg::FIFTH_IO_PORT_SLAVE_MODE];
              state_d.dirE      = wrData[2:0];
            end
          end
          bsr_pkg::ADDR_COUNTER_LATCH:  state_d.latch  = wrData[4:0];
          bsr_pkg::ADDR_IRQ_CONTROL: begin
            // Pin-change flag set in this cycle survives a clearing write
            state_d.irqCtl = wrData;
            state_d.irqCtl[bsr_pkg::IRQCTL_PIN_CHANGE_F] =
              wrData[bsr_pkg::IRQCTL_PIN_CHANGE_F] | pinChangeFlag;
          end
          bsr_pkg::ADDR_PERIPH_IRQ_EN1: state_d.irqEn1 = wrData;
          bsr_pkg::ADDR_PERIPH_IRQ_EN2: state_d.irqEn2 = wrData[0];
          bsr_pkg::ADDR_POWER_CONTROL:  state_d.pwr    = wrData[1:0];
          bsr_pkg::ADDR_PERIOD_LIMIT:   state_d.period = wrData;
          bsr_pkg::ADDR_SERIAL_ADDR:    state_d.serAddr = wrData;
          bsr_pkg::ADDR_TRANSMIT_CTRL: begin
            state_d.txCtl = wrData & bsr_pkg::TRANSMIT_CTRL_MASK;
          end
          bsr_pkg::ADDR_BAUD_DIVISOR:   state_d.baud   = wrData;
          bsr_pkg::ADDR_ANALOG_CFG:     state_d.analog = wrData[2:0];
          default: begin
            // Unimplemented and read-only locations ignore writes
            state_d.hit = state_d.hit;
          end
        endcase
      end
      // Overflow is set by the slave port; the set wins over a clear
      if (slaveOverflowSet) begin
        state_d.slaveOvf = 1'b1;
      end
      if (rdStb) begin
        state_d.rdata = readValue;
        state_d.hit   = decBus.hit;
      end
    end
  end

  // Asynchronous reset is power-on or brown-out
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= RESET_STATE;
    end else begin
      state_q <= state_d;
    end
  end

  // All outputs straight from the state register
  assign rdData       = state_q.rdata;
  assign rdHit        = state_q.hit;
  assign pcHigh       = state_q.pch;
  assign pcLow        = state_q.program_counter_low;
  assign cpuFlags     = state_q.flags;
  assign indirectPtr  = state_q.ptr;
  assign prescalerCfg = state_q.prescaler;
  assign portADir     = state_q.dirA;
  assign portBDir     = state_q.dirB;
  assign portCDir     = state_q.dirC;
  assign portDDir     = state_q.dirD;
  assign portEDir     = state_q.dirE;
  assign slaveMode    = state_q.slaveMode;
  assign irqControl   = state_q.irqCtl;
  assign periphIrqEn1 = state_q.irqEn1;
  assign periphIrqEn2 = state_q.irqEn2;
  assign periodLimit  = state_q.period;
  assign serialAddr   = state_q.serAddr;
  assign transmitCtrl = state_q.txCtl;
  assign baudDivisor  = state_q.baud;
  assign analogCfg    = state_q.analog;

endmodule

/* File: verification/bsr_bank1_chk.sv */
`timescale 1ns/10ps
module bsr_bank1_chk #(
  parameter bit HAS_PORT_D_E = 1'b1,
  parameter bit HAS_BROWNOUT = 1'b1
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       otherReset,
  input wire logic       resetByWatchdog,
  input wire logic       resetInSleep,
  input wire logic [6:0] dirAddr,
  input wire logic       rdStb,
  input wire logic       wrStb,
  input wire logic [7:0] wrData,
  input wire logic       pcBranch,
  input wire logic [7:0] pcBranchLow,
  input wire logic [7:0] rdData,
  input wire logic       rdHit,
  input wire logic [7:0] pcLow,
  input wire logic [7:0] cpuFlags,
  input wire logic [7:0] prescalerCfg,
  input wire logic [5:0] portADir,
  input wire logic [7:0] transmitCtrl,
  input wire logic [7:0] periodLimit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Direct requests that the register port takes while bank 1 is selected
  logic rdB1;
  logic wrB1;
  assign rdB1 = rdStb && !otherReset && cpuFlags[6:5] == 2'h1;
  assign wrB1 = wrStb && !otherReset && cpuFlags[6:5] == 2'h1;

  // Prescaler write and read; a read in the same cycle as a write would see old data
  sequence sWrPrescaler;
    wrB1 && !rdStb && dirAddr == 7'h01;
  endsequence
  sequence sRdPrescaler;
    rdB1 && !wrStb && dirAddr == 7'h01;
  endsequence

  a_write_lands: assert property (sWrPrescaler |=> prescalerCfg == $past(wrData))
    else $error("prescaler write did not land");
  a_write_readback: assert property (sWrPrescaler ##1 sRdPrescaler |=>
    rdHit && rdData == $past(wrData, 2)) else $error("read after write returned old data");
  a_hit_needs_read: assert property (rdHit |-> $past(rdStb) && !$past(otherReset))
    else $error("read hit without a taken read");
  a_unimpl_zero: assert property (rdB1 && dirAddr inside {7'h0F, 7'h10, 7'h11, 7'h15,
    7'h16, 7'h17, 7'h1A, 7'h1B, 7'h1C, 7'h1D, 7'h1E} |=> rdHit && rdData == 8'h00)
    else $error("unimplemented location read nonzero");
  a_bank0_miss: assert property (rdStb && !otherReset && cpuFlags[6:5] == 2'h0
    && dirAddr == 7'h01 |=> !rdHit) else $error("bank 0 location hit in bank 1");
  a_mirror_same: assert property (rdStb && !wrStb && !otherReset && !cpuFlags[6]
    && dirAddr == 7'h02 |=> rdHit && rdData == $past(pcLow))
    else $error("mirrored counter low read differs");
  a_branch_load: assert property (pcBranch && !otherReset && !wrStb |=>
    pcLow == $past(pcBranchLow)) else $error("branch did not load counter low");
  a_other_values: assert property (otherReset |=> prescalerCfg == 8'hFF
    && portADir == 6'h3F && transmitCtrl == 8'h02 && periodLimit == 8'hFF)
    else $error("other reset value wrong");
  a_cause_flags: assert property (otherReset |=> cpuFlags[7:3] ==
    {3'h0, !$past(resetByWatchdog), !$past(resetInSleep)}) else $error("reset cause flags wrong");
  a_reset_ignores: assert property (otherReset && rdStb |=> !rdHit)
    else $error("read taken during other reset");
  a_absent_ports: assert property (!HAS_PORT_D_E && rdB1 && dirAddr inside {7'h08, 7'h09}
    |=> rdData == 8'h00) else $error("absent port register read nonzero");
  a_no_brownout: assert property (!HAS_BROWNOUT && rdB1 && dirAddr == 7'h0E
    |=> rdData[0] == 1'h0) else $error("brownout flag read nonzero");
endmodule

bind bsr_bank1_regs bsr_bank1_chk #(
  .HAS_PORT_D_E(HAS_PORT_D_E),
  .HAS_BROWNOUT(HAS_BROWNOUT)
) chk (
  .clk(clk), .resetn(resetn), .otherReset(otherReset), .resetByWatchdog(resetByWatchdog),
  .resetInSleep(resetInSleep), .dirAddr(dirAddr), .rdStb(rdStb), .wrStb(wrStb),
  .wrData(wrData), .pcBranch(pcBranch), .pcBranchLow(pcBranchLow), .rdData(rdData),
  .rdHit(rdHit), .pcLow(pcLow), .cpuFlags(cpuFlags), .prescalerCfg(prescalerCfg),
  .portADir(portADir), .transmitCtrl(transmitCtrl), .periodLimit(periodLimit)
);

/* File: verification/tb_bsr_bank1_regs.sv */
`timescale 1ns/10ps
module tb_bsr_bank1_regs;
  logic       clk = 1'h0;
  logic       resetn = 1'h0;
  logic       otherReset = 1'h0, resetByWatchdog = 1'h0, resetInSleep = 1'h0;
  logic       rdStb = 1'h0, wrStb = 1'h0, aluFlagWe = 1'h0, pcStep = 1'h0, pcBranch = 1'h0;
  logic       sleepEnter = 1'h0, watchdogClear = 1'h0, pinChangeFlag = 1'h0;
  logic       slaveOverflowSet = 1'h0, rdHit;
  logic [6:0] dirAddr = 7'h00;
  logic [2:0] aluFlags = 3'h0;
  logic [4:0] pcHigh;
  logic [7:0] wrData = 8'h00, pcBranchLow = 8'h00;
  logic [7:0] rdData, pcLow, cpuFlags, indirectPtr, prescalerCfg, irqControl, rdDataLean;
  logic [7:0] portBDir, portCDir, portDDir, periphIrqEn1, serialAddr, baudDivisor;
  int         mismatches = 0;
  int         nTests = 0;
  // Rows: address, power-up read, write data, read after write
  logic [31:0] rows [18] = '{32'h01FF5A5A, 32'h053FFF3F, 32'h06FF1212, 32'h07FF3434,
    32'h08FF5656, 32'h0907FF17, 32'h0A00FF1F, 32'h0C002525, 32'h0D00FF01, 32'h0E00FF03,
    32'h0F00FF00, 32'h12FF0F0F, 32'h13003C3C, 32'h142AFF2A, 32'h1802FFF7, 32'h19007777,
    32'h1A00FF00, 32'h1F00FF07};

  // Live status inputs are held still so that read values are predictable
  bsr_bank1_regs uut (
    .clk(clk), .resetn(resetn), .otherReset(otherReset), .resetByWatchdog(resetByWatchdog),
    .resetInSleep(resetInSleep), .dirAddr(dirAddr), .rdStb(rdStb), .wrStb(wrStb),
    .wrData(wrData), .aluFlagWe(aluFlagWe), .aluFlags(aluFlags), .pcStep(pcStep),
    .pcBranch(pcBranch), .pcBranchLow(pcBranchLow), .sleepEnter(sleepEnter),
    .watchdogClear(watchdogClear), .pinChangeFlag(pinChangeFlag), .slaveBufStatus(2'h0),
    .slaveOverflowSet(slaveOverflowSet), .serialStatus(6'h2A), .txShiftEmpty(1'h1),
    .rdData(rdData), .rdHit(rdHit), .pcHigh(pcHigh), .pcLow(pcLow), .cpuFlags(cpuFlags),
    .indirectPtr(indirectPtr), .prescalerCfg(prescalerCfg), .portADir(), .portBDir(portBDir),
    .portCDir(portCDir), .portDDir(portDDir), .portEDir(), .slaveMode(),
    .irqControl(irqControl), .periphIrqEn1(periphIrqEn1), .periphIrqEn2(), .periodLimit(),
    .serialAddr(serialAddr), .transmitCtrl(), .baudDivisor(baudDivisor), .analogCfg()
  );

  // Reduced variant without ports D and E or brown-out, fed the same stimulus
  bsr_bank1_regs #(.HAS_PORT_D_E(1'b0), .HAS_BROWNOUT(1'b0)) uutLean (
    .clk(clk), .resetn(resetn), .otherReset(otherReset), .resetByWatchdog(resetByWatchdog),
    .resetInSleep(resetInSleep), .dirAddr(dirAddr), .rdStb(rdStb), .wrStb(wrStb),
    .wrData(wrData), .aluFlagWe(aluFlagWe), .aluFlags(aluFlags), .pcStep(pcStep),
    .pcBranch(pcBranch), .pcBranchLow(pcBranchLow), .sleepEnter(sleepEnter),
    .watchdogClear(watchdogClear), .pinChangeFlag(pinChangeFlag), .slaveBufStatus(2'h0),
    .slaveOverflowSet(slaveOverflowSet), .serialStatus(6'h2A), .txShiftEmpty(1'h1),
    .rdData(rdDataLean), .rdHit(), .pcHigh(), .pcLow(), .cpuFlags(), .indirectPtr(),
    .prescalerCfg(), .portADir(), .portBDir(), .portCDir(), .portDDir(), .portEDir(),
    .slaveMode(), .irqControl(), .periphIrqEn1(), .periphIrqEn2(), .periodLimit(),
    .serialAddr(), .transmitCtrl(), .baudDivisor(), .analogCfg()
  );

  always #5 clk = ~clk;

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    nTests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Called at a clock edge; the write is taken at the next edge and the task returns there
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    dirAddr <= a;
    wrData <= d;
    wrStb <= 1'h1;
    @(posedge clk);
    wrStb <= 1'h0;
  endtask

  // Answer lands at the same edge that takes the request, so sample just past that edge
  task automatic rd(input logic [6:0] a, input logic [7:0] exp, input logic hit);
    dirAddr <= a;
    rdStb <= 1'h1;
    @(posedge clk);
    rdStb <= 1'h0;
    #1;
    chk("rdHit", {7'h00, hit}, {7'h00, rdHit});
    if (hit) chk("rdData", exp, rdData);
    @(posedge clk);
  endtask

  // Hang guard well above the roughly 140 cycles the sequence needs
  initial begin
    #100000;
    mismatches++;
    end_sim;
  end

  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    wr(7'h03, 8'h20);
    foreach (rows[i]) begin
      rd(rows[i][30:24], rows[i][23:16], 1'h1);
      wr(rows[i][30:24], rows[i][15:8]);
      rd(rows[i][30:24], rows[i][7:0], 1'h1);
    end
    // The reduced variant reads its absent port and brown-out bit as zero
    rd(7'h08, 8'h56, 1'h1);
    chk("rdDataLean", 8'h00, rdDataLean);
    rd(7'h0E, 8'h03, 1'h1);
    chk("rdDataLean", 8'h02, rdDataLean);
    // Written values also stand on the register outputs
    chk("portBDir", 8'h12, portBDir);
    chk("portCDir", 8'h34, portCDir);
    chk("portDDir", 8'h56, portDDir);
    chk("periphIrqEn1", 8'h25, periphIrqEn1);
    chk("serialAddr", 8'h3C, serialAddr);
    chk("baudDivisor", 8'h77, baudDivisor);
    $display("test register table done");
    // Latch feeds the upper counter on a branch; a step carries out of the low byte
    wr(7'h03, 8'h00);
    rd(7'h01, 8'h00, 1'h0);
    wr(7'h0A, 8'h15);
    pcBranchLow <= 8'hFF;
    pcBranch <= 1'h1;
    @(posedge clk);
    pcBranch <= 1'h0;
    pcStep <= 1'h1;
    @(posedge clk);
    pcStep <= 1'h0;
    #1;
    chk("pcHigh", 8'h16, {3'h0, pcHigh});
    chk("pcLow", 8'h00, pcLow);
    @(posedge clk);
    wr(7'h03, 8'h20);
    rd(7'h0A, 8'h15, 1'h1);
    rd(7'h02, 8'h00, 1'h1);
    wr(7'h02, 8'h33);
    #1;
    chk("pcHigh", 8'h15, {3'h0, pcHigh});
    @(posedge clk);
    wr(7'h04, 8'h81);
    rd(7'h00, 8'h5A, 1'h1);
    $display("test counter and mirrors done");
    // Core side events land in the flags, interrupt and port E registers
    aluFlagWe <= 1'h1;
    aluFlags <= 3'h5;
    sleepEnter <= 1'h1;
    pinChangeFlag <= 1'h1;
    slaveOverflowSet <= 1'h1;
    @(posedge clk);
    aluFlagWe <= 1'h0;
    sleepEnter <= 1'h0;
    pinChangeFlag <= 1'h0;
    slaveOverflowSet <= 1'h0;
    watchdogClear <= 1'h1;
    #1;
    chk("cpuFlags", 8'h35, cpuFlags);
    chk("irqControl", 8'h01, irqControl);
    @(posedge clk);
    watchdogClear <= 1'h0;
    #1;
    chk("cpuFlags", 8'h3D, cpuFlags);
    @(posedge clk);
    rd(7'h09, 8'h37, 1'h1);
    $display("test core events done");
    // Pin or watchdog reset keeps pointer and low flags, sets cause flags
    otherReset <= 1'h1;
    resetByWatchdog <= 1'h1;
    @(posedge clk);
    otherReset <= 1'h0;
    resetByWatchdog <= 1'h0;
    #1;
    chk("cpuFlags", 8'h0D, cpuFlags);
    chk("indirectPtr", 8'h81, indirectPtr);
    chk("prescalerCfg", 8'hFF, prescalerCfg);
    @(posedge clk);
    otherReset <= 1'h1;
    resetInSleep <= 1'h1;
    dirAddr <= 7'h02;
    rdStb <= 1'h1;
    @(posedge clk);
    otherReset <= 1'h0;
    resetInSleep <= 1'h0;
    rdStb <= 1'h0;
    #1;
    chk("cpuFlags", 8'h15, cpuFlags);
    chk("rdHit", 8'h00, {7'h00, rdHit});
    @(posedge clk);
    $display("test other reset done");
    resetn <= 1'h0;
    @(posedge clk);
    #1;
    chk("cpuFlags", 8'h18, cpuFlags);
    chk("indirectPtr", 8'h00, indirectPtr);
    @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    $display("test second power-up reset done");
    end_sim;
  end
endmodule
